/* verification/tb.sv */
// Self-checking bench for the timer block over APB.
// Assumes the monitor is bound in and pin models drive the edge inputs.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tmr_pkg::*;
  logic              clk_sys = 1'b0, rst_b = 1'b0;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata;
  logic              pready, pslverr;
  logic [1:0]        matchAIrq, matchBIrq, run = 2'b00, idleHi = 2'b10;
  logic [7:0]        port0OutEnB;
  wire  [1:0]        pinA;
  wire  [3:0]        irqs = {matchBIrq, matchAIrq};
  logic [31:0]       rdQ[$];
  int                mismatches = 0, n_tests = 0, seed = 23, m;

  always #2.5 clk_sys = ~clk_sys;

  tmr_top uut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .edgeInA(pinA), .edgeInB({pinA[0], pinA[1]}),
    .matchAIrq, .matchBIrq, .port0OutEnB);
  tmr_pin_model pa0 (.clk_sys, .run(run[0]), .idleHi(idleHi[0]), .pin(pinA[0]));
  tmr_pin_model pa1 (.clk_sys, .run(run[1]), .idleHi(idleHi[1]), .pin(pinA[1]));

  //////////////////////////////////////////////////////////////////////
  // Compare, bus and closing tasks.
  task automatic cmp(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] ix, logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] ix, input logic [31:0] e);
    rdQ.push_back(e);
    apb(1'b0, ix, 32'h0);
  endtask

  // Waits for two pulses of one request and checks the spacing.
  task automatic per(input int k, input int e);
    int c;
    for (int i = 0; i < 2; i++) begin
      c = 0;
      do begin
        @(posedge clk_sys);
        c++;
      end while (irqs[k] !== 1'b1 && c < 3000);
    end
    cmp("irq period", e, c);
  endtask

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Read data is matched against the oldest expectation on the queue.
  always @(posedge clk_sys) begin
    if (psel && penable && !pwrite && pready)
      cmp("prdata", rdQ.pop_front(), prdata);
  end

  // Cuts a hung run short.
  initial begin
    #(5 * 60000);
    mismatches++;
    test_done();
  end

  //////////////////////////////////////////////////////////////////////
  // Main sequence; the prescale word is only written while stopped.
  initial begin
    logic [31:0] d;
    logic [1:0]  ec[3] = '{2'b00, 2'b01, 2'b11};
    int          dv[6] = '{1, 1 << T0_EXP1, 1 << T0_EXP2,
                           1, 1 << T1_EXP1, 1 << T1_EXP2};
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(IDX_PRESCALE0, 32'h0);
    rd(IDX_PRESCALE1, 32'h0);
    rd(IDX_PORT0DIR, 32'hFF);
    rd(16'h0000, 32'h0);
    @(negedge clk_sys);
    cmp("port0OutEnB", 32'hFF, {24'h0, port0OutEnB});
    d = $random(seed) | 32'h00000050; // Edge fields never hold 10.
    apb(1'b1, IDX_PRESCALE1, d);
    rd(IDX_PRESCALE1, {24'h0, d[7:0] & PRESCALE_WMASK});
    apb(1'b1, IDX_PORT0DIR, d >> 8);
    @(negedge clk_sys);
    cmp("port0OutEnB", {24'h0, d[15:8]}, {24'h0, port0OutEnB});
    // First enable of timer 1 with its input already high, then again.
    apb(1'b1, IDX_PRESCALE1, 32'h13);
    apb(1'b1, IDX_CMPA1, 32'h1);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, IDX_MODE1, 32'h3);
      repeat (10) @(posedge clk_sys);
      rd(IDX_COUNT1, i == 0 ? 32'h1 : 32'h0);
      apb(1'b1, IDX_MODE1, 32'h0);
    end
    // Timer 0 counting edges of input A for edge codes 00, 01 and 11.
    foreach (ec[i]) begin
      apb(1'b1, IDX_PRESCALE0, {24'h0, 2'b00, ec[i], 4'h3});
      apb(1'b1, IDX_CMPA0, 32'h2);
      run[0] <= 1'b1;
      apb(1'b1, IDX_MODE0, 32'h3);
      per(0, ec[i] == 2'b11 ? 12 : 24);
      apb(1'b1, IDX_MODE0, 32'h0);
      run[0] <= 1'b0;
    end
    // Interval mode on each internal source of both timers.
    for (int i = 0; i < 6; i++) begin
      m = 1 + ($random(seed) & 3);
      apb(1'b1, i < 3 ? IDX_PRESCALE0 : IDX_PRESCALE1, i % 3);
      apb(1'b1, IDX_CMPA0 + 16'(4 * (i / 3)), m);
      apb(1'b1, IDX_MODE0 + 16'(4 * (i / 3)), 32'h3);
      per(i / 3, (m + 1) * dv[i]);
      if (i == 2) begin
        repeat (300) @(posedge clk_sys);
        rd(IDX_COUNT0, 32'h1);
      end
      apb(1'b1, IDX_MODE0 + 16'(4 * (i / 3)), 32'h0);
    end
    // Match B unmasked, then masked again.
    apb(1'b1, IDX_PRESCALE0, 32'h0);
    apb(1'b1, IDX_CMPA0, 32'h5);
    apb(1'b1, IDX_CMPB0, 32'h2);
    apb(1'b1, IDX_IRQMASK, 32'h2);
    apb(1'b1, IDX_MODE0, 32'h3);
    per(2, 6);
    apb(1'b1, IDX_IRQMASK, 32'h3);
    repeat (20) @(posedge clk_sys);
    apb(1'b1, IDX_MODE0, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire

/* verification/tmr_monitor.sv */
// Checker for the timer block: bus answers, pin direction and requests.
// Assumes it is bound to tmr_top and sees nothing but its ports.
`timescale 1ns/1ps
`default_nettype none
module tmr_monitor
  import tmr_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst_b,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [1:0]        edgeInA,
  input wire logic [1:0]        edgeInB,
  input wire logic [1:0]        matchAIrq,
  input wire logic [1:0]        matchBIrq,
  input wire logic [7:0]        port0OutEnB
);
  //////////////////////////////////////////////////////////////////////
  // Bus decode; mode, compare and count words form one block of indices.
  logic [7:0]  sh0, sh1;
  logic [1:0]  msk;
  wire  [15:0] idx    = paddr[17:2];
  wire  [7:0]  wLow   = pwdata[7:0];
  wire         acc    = psel && penable;
  wire         wrAcc  = acc && pwrite;
  wire         mapped = paddr[1:0] == 2'h0 && (idx == IDX_PRESCALE0 ||
    idx == IDX_PRESCALE1 || (idx >= IDX_MODE0 && idx <= IDX_IRQMASK));

  // Shadow copies of the prescale words and the match B mask.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sh0 <= RST_PRESCALE;
      sh1 <= RST_PRESCALE;
      msk <= RST_IRQMASK;
    end else if (wrAcc && mapped) begin
      if (idx == IDX_PRESCALE0) sh0 <= wLow & PRESCALE_WMASK;
      if (idx == IDX_PRESCALE1) sh1 <= wLow & PRESCALE_WMASK;
      if (idx == IDX_IRQMASK) msk <= pwdata[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Relations between the bus, the registers and the request pins.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_pre_read: assert property (acc && !pwrite &&
    (idx == IDX_PRESCALE0 || idx == IDX_PRESCALE1) |->
    prdata == {24'h0, (idx == IDX_PRESCALE0) ? sh0 : sh1})
    else $error("prescale read mismatch");
  a_dir_write: assert property (wrAcc && idx == IDX_PORT0DIR
    |=> port0OutEnB == $past(wLow)) else $error("direction not applied");
  a_dir_reset: assert property ($rose(rst_b) |->
    port0OutEnB == RST_PORT0DIR) else $error("direction reset wrong");
  a_bad_read: assert property (acc && !pwrite && !mapped |->
    prdata == 32'h0 && pslverr) else $error("unmapped read wrong");
  a_good_ok: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped word");
  a_err_phase: assert property (pslverr |-> acc)
    else $error("error outside access");
  a_irqa_gap: assert property (|matchAIrq |=>
    (matchAIrq & $past(matchAIrq)) == 2'b00) else $error("match A twice");
  a_irqb_mask: assert property (
    (matchBIrq & msk & $past(msk) & $past(msk, 2)) == 2'b00)
    else $error("masked match B raised");
  c_irqa0: cover property (matchAIrq[0]);
  c_irqa1: cover property (matchAIrq[1]);
  c_irqb0: cover property (matchBIrq[0]);
  c_err: cover property (pslverr);
endmodule

bind tmr_top tmr_monitor mon (.clk_sys, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .edgeInA, .edgeInB,
  .matchAIrq, .matchBIrq, .port0OutEnB);
`default_nettype wire

/* verification/tmr_pin_model.sv */
// Model of one external edge input pin: a square wave source.
// Assumes the bench starts and stops it between count runs.
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model #(
  parameter int HALF = 4
) (
  input  wire logic clk_sys,
  input  wire logic run,
  input  wire logic idleHi,
  output var logic  pin = 1'b0
);
  int cnt = 0;

  // Each level lasts HALF clocks, longer than the pulse minimum.
  always @(posedge clk_sys) begin
    if (!run) begin
      pin <= idleHi;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      pin <= !pin;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

/* verilog/tmr_clk_if.sv */
// Count clock path between the timer core and its edge and prescale units.
// Assumes all members run on the one system clock.
`timescale 1ns/1ps
`default_nettype none
interface tmr_clk_if;
  logic       run;
  logic [1:0] srcSel;
  logic [1:0] edgeSel;
  logic       pinLevel;
  logic       edgeHit;
  logic       countTick;

  modport edge_unit (input run, edgeSel, pinLevel, output edgeHit);
  modport pre_unit  (input run, srcSel, edgeHit, output countTick);
  modport core      (output run, srcSel, edgeSel, pinLevel,
                     input edgeHit, countTick);
endinterface
`default_nettype wire

/* verilog/tmr_edge_detect.sv */
// Valid-edge detector for one timer input pin.
// Assumes the pin level is already synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module tmr_edge_detect
  import tmr_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_b,
  tmr_clk_if.edge_unit cif
);

  logic sampleNow;
  logic samplePrev;
  logic everRun;
  logic rise;
  logic fall;

  // Two samples in a row make a level; the older one is compared.
  // Before the first enable the old sample stays low, so a high pin
  // reads as a rising edge; later it tracks the pin even when stopped.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sampleNow  <= 1'b0;
      samplePrev <= 1'b0;
      everRun    <= 1'b0;
    end else begin
      sampleNow  <= cif.pinLevel;
      samplePrev <= (everRun || cif.run) ? sampleNow : 1'b0;
      everRun    <= everRun | cif.run;
    end
  end

  // Edge type selection applied after the compare.
  assign rise = sampleNow & ~samplePrev;
  assign fall = ~sampleNow & samplePrev;
  assign cif.edgeHit = cif.run & (
      (cif.edgeSel == EDGE_FALL && fall) ||
      (cif.edgeSel == EDGE_RISE && rise) ||
      (cif.edgeSel == EDGE_BOTH && (rise || fall)));

endmodule
`default_nettype wire

/* verilog/tmr_pkg.sv */
// Constants shared by the timer prescaler and interval timer design.
// Assumes a 32-bit APB slave with each register in one aligned word.
package tmr_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_PRESCALE1 = 16'hFFB7;
  localparam logic [15:0] IDX_PRESCALE0 = 16'hFFBB;
  localparam logic [15:0] IDX_MODE0     = 16'hFFC0;
  localparam logic [15:0] IDX_CMPA0     = 16'hFFC1;
  localparam logic [15:0] IDX_CMPB0     = 16'hFFC2;
  localparam logic [15:0] IDX_COUNT0    = 16'hFFC3;
  localparam logic [15:0] IDX_MODE1     = 16'hFFC4;
  localparam logic [15:0] IDX_CMPA1     = 16'hFFC5;
  localparam logic [15:0] IDX_CMPB1     = 16'hFFC6;
  localparam logic [15:0] IDX_COUNT1    = 16'hFFC7;
  localparam logic [15:0] IDX_PORT0DIR  = 16'hFFC8;
  localparam logic [15:0] IDX_IRQMASK   = 16'hFFC9;

  // Address width of the bus: index plus two byte bits.
  localparam int ADDR_W = 18;

  // Reset values.
  localparam logic [7:0]  RST_PRESCALE = 8'h00;
  localparam logic [7:0]  RST_PORT0DIR = 8'hFF;
  localparam logic [1:0]  RST_MODE     = 2'h0;
  localparam logic [15:0] RST_CMP      = 16'h0000;
  localparam logic [15:0] RST_COUNT    = 16'h0000;
  localparam logic [1:0]  RST_IRQMASK  = 2'h3;

  // Prescale select field layout; bits 3 and 2 read as zero.
  localparam int F_SRC_LO   = 0;
  localparam int F_EDGEA_LO = 4;
  localparam int F_EDGEB_LO = 6;
  localparam logic [7:0] PRESCALE_WMASK = 8'hF3;

  // Clock source select codes.
  typedef enum logic [1:0] {
    SRC_FULL  = 2'b00,
    SRC_DIV1  = 2'b01,
    SRC_DIV2  = 2'b10,
    SRC_EDGEA = 2'b11
  } tmr_src_t;

  // Edge select codes; 10 must not be written by software.
  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_NONE = 2'b10,
    EDGE_BOTH = 2'b11
  } tmr_edge_t;

  // Operating mode codes.
  localparam logic [1:0] MODE_STOP     = 2'b00;
  localparam logic [1:0] MODE_CMPCLEAR = 2'b11;

  // Divider exponents per timer: 2 and 8, then 4 and 6.
  localparam int DIV_W     = 8;
  localparam int T0_EXP1   = 2;
  localparam int T0_EXP2   = 8;
  localparam int T1_EXP1   = 4;
  localparam int T1_EXP2   = 6;

endpackage

/* verilog/tmr_prescale.sv */
// Count clock selector: full rate, two divided rates or the pin edge.
// Assumes the divider is only needed while the timer runs.
`timescale 1ns/1ps
`default_nettype none
module tmr_prescale
  import tmr_pkg::*;
#(
  parameter int EXP1 = T0_EXP1,
  parameter int EXP2 = T0_EXP2
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  tmr_clk_if.pre_unit cif
);

  logic [DIV_W-1:0] divCount;
  logic             div1Tick;
  logic             div2Tick;

  // Free divider, held at zero while stopped so phase starts fresh.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      divCount <= '0;
    end else begin
      divCount <= cif.run ? divCount + 1'b1 : '0;
    end
  end

  // One tick per 2^EXP clocks.
  assign div1Tick = &divCount[EXP1-1:0];
  assign div2Tick = &divCount[EXP2-1:0];
  assign cif.countTick = cif.run & (
      (cif.srcSel == SRC_FULL)                ||
      (cif.srcSel == SRC_DIV1  && div1Tick)   ||
      (cif.srcSel == SRC_DIV2  && div2Tick)   ||
      (cif.srcSel == SRC_EDGEA && cif.edgeHit));

endmodule
`default_nettype wire

/* verilog/tmr_top.sv */
// Two 16-bit interval timers with prescale, edge select and port-0
// direction, reached over APB.
// Assumes pins and bus are synchronous to clk_sys.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tmr_top
  import tmr_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [1:0]        edgeInA,
  input  wire logic [1:0]        edgeInB,
  output logic      [1:0]        matchAIrq,
  output logic      [1:0]        matchBIrq,
  output logic      [7:0]        port0OutEnB
);

  ////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic [7:0]  prescale [2];
  logic [1:0]  mode     [2];
  logic [15:0] cmpA     [2];
  logic [15:0] cmpB     [2];
  logic [15:0] count    [2];
  logic [7:0]  port0Dir;
  logic [1:0]  irqMaskB;
  logic [1:0]  edgeHitB;

  ////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic [15:0] regIdx;
  logic        addrAligned;
  logic        hitPre0;
  logic        hitPre1;
  logic        hitMode0;
  logic        hitMode1;
  logic        hitCmpA0;
  logic        hitCmpA1;
  logic        hitCmpB0;
  logic        hitCmpB1;
  logic        hitCount0;
  logic        hitCount1;
  logic        hitDir;
  logic        hitMask;
  logic        hitAny;
  logic        setupRd;
  logic        accessWr;
  logic [31:0] readMux;

  // Index and word alignment of the request.
  assign regIdx      = paddr[ADDR_W-1:2];
  assign addrAligned = (paddr[1:0] == 2'b00);
  assign hitPre0   = addrAligned && regIdx == IDX_PRESCALE0;
  assign hitPre1   = addrAligned && regIdx == IDX_PRESCALE1;
  assign hitMode0  = addrAligned && regIdx == IDX_MODE0;
  assign hitMode1  = addrAligned && regIdx == IDX_MODE1;
  assign hitCmpA0  = addrAligned && regIdx == IDX_CMPA0;
  assign hitCmpA1  = addrAligned && regIdx == IDX_CMPA1;
  assign hitCmpB0  = addrAligned && regIdx == IDX_CMPB0;
  assign hitCmpB1  = addrAligned && regIdx == IDX_CMPB1;
  assign hitCount0 = addrAligned && regIdx == IDX_COUNT0;
  assign hitCount1 = addrAligned && regIdx == IDX_COUNT1;
  assign hitDir    = addrAligned && regIdx == IDX_PORT0DIR;
  assign hitMask   = addrAligned && regIdx == IDX_IRQMASK;
  assign hitAny    = hitPre0 | hitPre1 | hitMode0 | hitMode1 |
                     hitCmpA0 | hitCmpA1 | hitCmpB0 | hitCmpB1 |
                     hitCount0 | hitCount1 | hitDir | hitMask;

  // Phase strobes; writes land only in the access phase.
  assign setupRd  = psel & ~penable & ~pwrite;
  assign accessWr = psel & penable & pwrite & hitAny;

  // Read selection; the counter read shows the live count.
  assign readMux =
      hitPre0   ? {24'h000000, prescale[0]} :
      hitPre1   ? {24'h000000, prescale[1]} :
      hitMode0  ? {30'h00000000, mode[0]}   :
      hitMode1  ? {30'h00000000, mode[1]}   :
      hitCmpA0  ? {16'h0000, cmpA[0]}       :
      hitCmpA1  ? {16'h0000, cmpA[1]}       :
      hitCmpB0  ? {16'h0000, cmpB[0]}       :
      hitCmpB1  ? {16'h0000, cmpB[1]}       :
      hitCount0 ? {16'h0000, count[0]}      :
      hitCount1 ? {16'h0000, count[1]}      :
      hitDir    ? {24'h000000, port0Dir}    :
      hitMask   ? {30'h00000000, irqMaskB}  :
                  32'h00000000;

  // Zero-wait slave: data is latched in setup, the access ends at once.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hitAny;

  ////////////////////////////////////////////////////////////////////////
  // Read data register.

  // Captured in the setup cycle so it stands through the access phase.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (setupRd) begin
      prdata <= readMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  // Port-0 direction; every pin comes out of reset as an input, so
  // nothing is driven until software asks for it.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port0Dir <= RST_PORT0DIR;
    end else if (accessWr && hitDir) begin
      port0Dir <= pwdata[7:0];
    end
  end

  // Match B mask, one bit per timer; a set bit holds the request back.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irqMaskB <= RST_IRQMASK;
    end else if (accessWr && hitMask) begin
      irqMaskB <= pwdata[1:0];
    end
  end

  // Direction 0 turns the output buffer on, so the enable is active low.
  assign port0OutEnB = port0Dir;

  ////////////////////////////////////////////////////////////////////////
  // Per-timer count path.

  genvar n;
  generate
    for (n = 0; n < 2; n++) begin : gTimer
      tmr_clk_if cifA ();
      tmr_clk_if cifB ();
      logic       isRun;
      logic       hitA;
      logic       hitB;
      logic       matchAQ;
      logic       matchBQ;
      logic       wrPre;
      logic       wrMode;
      logic       wrCmpA;
      logic       wrCmpB;
      logic [15:0] next_count;

      // Write strobes of this timer's own registers; the index decode
      // is shared, so each timer only picks its own hits.
      assign wrPre  = accessWr && (n == 0 ? hitPre0  : hitPre1);
      assign wrMode = accessWr && (n == 0 ? hitMode0 : hitMode1);
      assign wrCmpA = accessWr && (n == 0 ? hitCmpA0 : hitCmpA1);
      assign wrCmpB = accessWr && (n == 0 ? hitCmpB0 : hitCmpB1);

      // Prescale select; writes are taken at any time and software
      // keeps them to a stopped timer. Reserved bits 3 and 2 never store.
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          prescale[n] <= RST_PRESCALE;
        end else if (wrPre) begin
          prescale[n] <= pwdata[7:0] & PRESCALE_WMASK;
        end
      end

      // Operating mode; 00 stops the timer and clears count and divider.
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          mode[n] <= RST_MODE;
        end else if (wrMode) begin
          mode[n] <= pwdata[1:0];
        end
      end

      // Compare A; the interval is this value plus one count clock.
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          cmpA[n] <= RST_CMP;
        end else if (wrCmpA) begin
          cmpA[n] <= pwdata[15:0];
        end
      end

      // Compare B; its match is only a request, never a clear.
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          cmpB[n] <= RST_CMP;
        end else if (wrCmpB) begin
          cmpB[n] <= pwdata[15:0];
        end
      end

      // Any mode but stop runs the timer.
      assign isRun          = (mode[n] != MODE_STOP);

      // Input A path; its valid edge may serve as the count clock.
      assign cifA.run       = isRun;
      assign cifA.srcSel    = prescale[n][F_SRC_LO+1:F_SRC_LO];
      assign cifA.edgeSel   = prescale[n][F_EDGEA_LO+1:F_EDGEA_LO];
      assign cifA.pinLevel  = edgeInA[n];

      // Input B path; its edge is selected but never clocks the counter.
      assign cifB.run       = isRun;
      assign cifB.srcSel    = SRC_FULL;
      assign cifB.edgeSel   = prescale[n][F_EDGEB_LO+1:F_EDGEB_LO];
      assign cifB.pinLevel  = edgeInB[n];
      assign edgeHitB[n]    = cifB.edgeHit;

      tmr_edge_detect uEdgeA (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .cif     (cifA)
      );

      tmr_edge_detect uEdgeB (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .cif     (cifB)
      );

      tmr_prescale #(
        .EXP1 (n == 0 ? T0_EXP1 : T1_EXP1),
        .EXP2 (n == 0 ? T0_EXP2 : T1_EXP2)
      ) uPre (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .cif     (cifA)
      );

      // The second unit's tick is not used as a count clock.
      assign cifB.countTick = 1'b0;

      // Matches are judged on a count clock tick; in compare-clear mode
      // match A wraps to zero, giving compare plus one ticks per period.
      assign hitA = cifA.countTick && count[n] == cmpA[n];
      assign hitB = cifA.countTick && count[n] == cmpB[n];
      assign next_count =
          !isRun                                   ? RST_COUNT :
          !cifA.countTick                          ? count[n]  :
          (mode[n] == MODE_CMPCLEAR && hitA)       ? RST_COUNT :
                                                     count[n] + 16'h0001;

      // Counter; mode 11 starts it in step with the count clock.
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          count[n] <= RST_COUNT;
        end else begin
          count[n] <= next_count;
        end
      end

      // Request flops; match B is raised in any running mode, and only
      // the mask bit keeps it off the pin.
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          matchAQ  <= 1'b0;
          matchBQ  <= 1'b0;
        end else begin
          matchAQ  <= hitA;
          matchBQ  <= hitB & ~irqMaskB[n];
        end
      end

      // Request pulses, one clock each.
      assign matchAIrq[n] = matchAQ;
      assign matchBIrq[n] = matchBQ;
    end
  endgenerate

endmodule
`default_nettype wire
